// *** hdl/display_sync_gpio_pkg.sv ***
// Purpose: shared constants and types for the display sync override and pin pair block
// Assumes: 32-bit register words, 16-bit register addresses
// Notes: pin control lanes use the same five-bit layout in every lane
package display_sync_gpio_pkg;

	// register port shape
	localparam int ADDR_W = 16; // register address width
	localparam int DATA_W = 32; // register data width

	// register byte addresses
	localparam logic [15:0] SYNC_OVERRIDE_CONTROL_OFFSET = 16'h5000;
	localparam logic [15:0] MONITOR_CHANNEL_PIN_CONTROL_OFFSET = 16'h5010;
	localparam logic [15:0] VIDEO_OUT_PIN_CONTROL_OFFSET = 16'h5014;

	// sync override field positions
	localparam int SYNC_KEEP_ALIVE_BIT = 0; // syncs stay active while the dac is off
	localparam int SYNC_FIELD_LSB = 16; // low bit of the four-bit override field
	localparam int SYNC_FIELD_W = 4; // override field width

	// override field codes for monitor power states
	localparam logic [3:0] PWR_STATE_ON = 4'h0; // pulse both
	localparam logic [3:0] PWR_STATE_STANDBY = 4'h2; // pulse vertical only
	localparam logic [3:0] PWR_STATE_SUSPEND = 4'h8; // pulse horizontal only
	localparam logic [3:0] PWR_STATE_OFF = 4'hA; // no pulses

	// pin pair lanes: clock pin in bits 4..0, data pin in bits 12..8
	localparam int CLOCK_LANE_LSB = 0;
	localparam int DATA_LANE_LSB = 8;
	localparam int LANE_W = 5; // width of one pin's control lane

	// pin indices on the pin vectors
	localparam int MONITOR_CHANNEL_CLOCK_PIN = 0;
	localparam int MONITOR_CHANNEL_DATA_PIN = 1;
	localparam int VIDEO_OUT_CLOCK_PIN = 2;
	localparam int VIDEO_OUT_DATA_PIN = 3;
	localparam int PIN_COUNT = 4;

	// values after reset
	localparam logic [31:0] SYNC_OVERRIDE_RESET = 32'h0000_0000;
	localparam logic [4:0] PIN_LANE_RESET = 5'h00;
	localparam logic [31:0] READ_IDLE_VALUE = 32'h0000_0000;

	// one pin's control lane, msb first as laid out in the register
	typedef struct packed {
		logic sampled_in; // captured pin level, read only
		logic out_level; // stored output level
		logic level_mask; // companion mask for out_level
		logic drive_en; // stored direction, 1 drives the pin
		logic drive_mask; // companion mask for drive_en
	} pin_lane_t;

	// sync override register contents
	typedef struct packed {
		logic v_force; // vertical override enable
		logic v_level; // forced vertical level
		logic h_force; // horizontal override enable
		logic h_level; // forced horizontal level
		logic keep_alive; // syncs live while the dac is off
	} sync_ctl_t;

endpackage : display_sync_gpio_pkg

// *** hdl/display_sync_gpio.sv ***
// Purpose: sync override for monitor power states and two masked-write pin pairs
// Assumes: one 100 MHz clock, plain register port, pin inputs may change at any time
// Notes: every write to a pin pair register is a write to all of its bytes
`timescale 1ns/1ps
`default_nettype none

module display_sync_gpio
	import display_sync_gpio_pkg::*;
(
	input wire logic i_core_clk, // 100 MHz register clock
	input wire logic i_nrst, // async reset, active low
	input wire logic [ADDR_W-1:0] i_addr, // register byte address
	input wire logic [DATA_W-1:0] i_wdata, // write data
	input wire logic i_wr, // one-cycle write strobe
	input wire logic i_rd, // one-cycle read strobe
	output logic [DATA_W-1:0] o_rdata, // read data, cycle after i_rd
	input wire logic i_hsync_normal, // timing generator horizontal sync
	input wire logic i_vsync_normal, // timing generator vertical sync
	input wire logic i_dac_enable, // internal dac on, from power clock control
	output logic o_hsync, // horizontal sync pin
	output logic o_vsync, // vertical sync pin
	input wire logic [PIN_COUNT-1:0] i_pin_in, // pin levels seen on the wires
	output logic [PIN_COUNT-1:0] o_pin_out, // pin drive levels
	output logic [PIN_COUNT-1:0] o_pin_oe // pin drive enables, high drives
);

	logic rst_meta_q; // first reset release stage
	logic rst_n; // synchronised reset, active low
	sync_ctl_t sync_q; // sync override register
	logic sync_active; // syncs allowed to toggle
	logic hsync_q; // registered horizontal pin
	logic vsync_q; // registered vertical pin
	logic [PIN_COUNT-1:0] pin_meta_q; // first synchroniser stage
	logic [PIN_COUNT-1:0] pin_sync_q; // second synchroniser stage
	pin_lane_t pin_q [PIN_COUNT]; // per-pin control lanes
	logic sel_sync; // address hits sync register
	logic sel_mon; // address hits monitor channel pair
	logic sel_vid; // address hits video-out pair
	logic [DATA_W-1:0] rdata_q; // read data register

	// reset release: assert at once, release after two clean edges
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// address decode
	assign sel_sync = (i_addr == SYNC_OVERRIDE_CONTROL_OFFSET);
	assign sel_mon = (i_addr == MONITOR_CHANNEL_PIN_CONTROL_OFFSET);
	assign sel_vid = (i_addr == VIDEO_OUT_PIN_CONTROL_OFFSET);

	// sync override register; enable and level land in the same write
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_q <= sync_ctl_t'({SYNC_OVERRIDE_RESET[SYNC_FIELD_LSB +: SYNC_FIELD_W],
				SYNC_OVERRIDE_RESET[SYNC_KEEP_ALIVE_BIT]});
		end else if (i_wr && sel_sync) begin
			sync_q <= sync_ctl_t'({i_wdata[SYNC_FIELD_LSB +: SYNC_FIELD_W],
				i_wdata[SYNC_KEEP_ALIVE_BIT]});
		end
	end

	// dac off silences both syncs unless software keeps them alive
	assign sync_active = sync_q.keep_alive | i_dac_enable;

	// sync pins: deactivation wins over override so a powered-down dac stays quiet
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hsync_q <= 1'b0;
			vsync_q <= 1'b0;
		end else if (!sync_active) begin
			hsync_q <= 1'b0;
			vsync_q <= 1'b0;
		end else begin
			hsync_q <= sync_q.h_force ? sync_q.h_level : i_hsync_normal;
			vsync_q <= sync_q.v_force ? sync_q.v_level : i_vsync_normal;
		end
	end

	assign o_hsync = hsync_q;
	assign o_vsync = vsync_q;

	// pin input synchroniser; the pins move with no relation to our clock
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= i_pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// per-pin lanes: pins 0,1 live in the monitor channel word, 2,3 in the video-out word
	for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
		localparam int LANE_LSB = (p % 2 == 0) ? CLOCK_LANE_LSB : DATA_LANE_LSB;
		logic hit; // write lands on this pin's register
		pin_lane_t wr_lane; // written lane bits
		assign hit = i_wr && ((p < 2) ? sel_mon : sel_vid);
		assign wr_lane = pin_lane_t'(i_wdata[LANE_LSB +: LANE_W]);

		// masked update; masks themselves are stored as written
		always_ff @(posedge i_core_clk or negedge rst_n) begin
			if (!rst_n) begin
				pin_q[p] <= pin_lane_t'(PIN_LANE_RESET);
			end else if (hit) begin
				pin_q[p].level_mask <= wr_lane.level_mask;
				pin_q[p].drive_mask <= wr_lane.drive_mask;
				if (wr_lane.level_mask) begin
					pin_q[p].out_level <= wr_lane.out_level;
				end
				if (wr_lane.drive_mask) begin
					pin_q[p].drive_en <= wr_lane.drive_en;
				end
				// fresh sample only on a write, hence the dummy write before a read
				pin_q[p].sampled_in <= pin_sync_q[p];
			end
		end

		// drive only while configured as output
		assign o_pin_oe[p] = pin_q[p].drive_en;
		assign o_pin_out[p] = pin_q[p].out_level;
	end

	// read data, valid only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= READ_IDLE_VALUE;
		end else if (!i_rd) begin
			rdata_q <= READ_IDLE_VALUE;
		end else if (sel_sync) begin
			rdata_q <= {12'h000, sync_q.v_force, sync_q.v_level, sync_q.h_force,
				sync_q.h_level, 15'h0000, sync_q.keep_alive};
		end else if (sel_mon) begin
			rdata_q <= {19'h0_0000, pin_q[MONITOR_CHANNEL_DATA_PIN], 3'h0,
				pin_q[MONITOR_CHANNEL_CLOCK_PIN]};
		end else if (sel_vid) begin
			rdata_q <= {19'h0_0000, pin_q[VIDEO_OUT_DATA_PIN], 3'h0,
				pin_q[VIDEO_OUT_CLOCK_PIN]};
		end else begin
			rdata_q <= READ_IDLE_VALUE; // unmapped
		end
	end

	assign o_rdata = rdata_q;

	// checks on the design's own outputs and internal registers
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	logic mon_hit; // helper: write to monitor channel word
	assign mon_hit = i_wr && sel_mon;
	logic vid_hit; // helper: write to video-out word
	assign vid_hit = i_wr && sel_vid;

	sequence s_force_vhigh;
		i_wr && sel_sync && i_wdata[19] && i_wdata[18] && i_wdata[SYNC_KEEP_ALIVE_BIT];
	endsequence

	sequence s_vpin_high;
		##2 o_vsync;
	endsequence

	property p_standby_code;
		({sync_q.v_force, sync_q.v_level, sync_q.h_force, sync_q.h_level} == PWR_STATE_STANDBY)
			&& sync_active |=> !o_hsync && (o_vsync == $past(i_vsync_normal));
	endproperty
	a_standby_code: assert property (p_standby_code) else $error("standby code sync mismatch");

	property p_off_code;
		({sync_q.v_force, sync_q.v_level, sync_q.h_force, sync_q.h_level} == PWR_STATE_OFF)
			|=> !o_hsync && !o_vsync;
	endproperty
	a_off_code: assert property (p_off_code) else $error("power off code left a sync pulsing");

	property p_v_force;
		sync_active && sync_q.v_force |=> o_vsync == $past(sync_q.v_level);
	endproperty
	a_v_force: assert property (p_v_force) else $error("vertical override level not driven");

	property p_h_normal;
		sync_active && !sync_q.h_force |=> o_hsync == $past(i_hsync_normal);
	endproperty
	a_h_normal: assert property (p_h_normal) else $error("horizontal sync not passed through");

	property p_one_write_force;
		s_force_vhigh |-> s_vpin_high;
	endproperty
	a_one_write_force: assert property (p_one_write_force) else $error("single write did not force vsync");

	property p_dac_off;
		!sync_q.keep_alive && !i_dac_enable |=> !o_hsync && !o_vsync;
	endproperty
	a_dac_off: assert property (p_dac_off) else $error("syncs active while dac off");

	property p_capture_only_on_write;
		!mon_hit |=> $stable(pin_q[MONITOR_CHANNEL_CLOCK_PIN].sampled_in);
	endproperty
	a_capture_only_on_write: assert property (p_capture_only_on_write) else $error("input bit moved without write");

	property p_level_masked;
		mon_hit && !i_wdata[CLOCK_LANE_LSB + 2] |=> $stable(o_pin_out[MONITOR_CHANNEL_CLOCK_PIN]);
	endproperty
	a_level_masked: assert property (p_level_masked) else $error("level changed without mask");

	property p_dir_written;
		mon_hit && i_wdata[DATA_LANE_LSB] |=> o_pin_oe[MONITOR_CHANNEL_DATA_PIN] == $past(i_wdata[DATA_LANE_LSB + 1]);
	endproperty
	a_dir_written: assert property (p_dir_written) else $error("direction not taken with mask");

	property p_reset_input;
		$rose(rst_n) |-> o_pin_oe == '0;
	endproperty
	a_reset_input: assert property (p_reset_input) else $error("pin driven after reset");

	property p_vid_readback;
		i_rd && sel_vid |=> o_rdata[DATA_LANE_LSB +: LANE_W] == pin_q[VIDEO_OUT_DATA_PIN];
	endproperty
	a_vid_readback: assert property (p_vid_readback) else $error("video-out readback wrong");

	property p_sync_depth;
		mon_hit ##1 $past(rst_n, 3) |-> pin_q[MONITOR_CHANNEL_CLOCK_PIN].sampled_in == $past(i_pin_in[0], 3);
	endproperty
	a_sync_depth: assert property (p_sync_depth) else $error("captured pin not two flops late");

	// suspend forces vertical low while horizontal keeps pulsing
	property p_suspend_code;
		({sync_q.v_force, sync_q.v_level, sync_q.h_force, sync_q.h_level} == PWR_STATE_SUSPEND)
			&& sync_active |=> !o_vsync && (o_hsync == $past(i_hsync_normal));
	endproperty
	a_suspend_code: assert property (p_suspend_code) else $error("suspend code sync mismatch");

	// power on: both syncs follow the timing generator
	property p_on_code;
		({sync_q.v_force, sync_q.v_level, sync_q.h_force, sync_q.h_level} == PWR_STATE_ON) && sync_active
			|=> (o_hsync == $past(i_hsync_normal)) && (o_vsync == $past(i_vsync_normal));
	endproperty
	a_on_code: assert property (p_on_code) else $error("power on code blocked a sync");

	// vertical pin passes the timing generator while not overridden
	property p_v_normal;
		sync_active && !sync_q.v_force |=> o_vsync == $past(i_vsync_normal);
	endproperty
	a_v_normal: assert property (p_v_normal) else $error("vertical sync not passed through");

	// horizontal override puts the stored level on the pin
	property p_h_force;
		sync_active && sync_q.h_force |=> o_hsync == $past(sync_q.h_level);
	endproperty
	a_h_force: assert property (p_h_force) else $error("horizontal override level not driven");

	// enables and levels of both syncs land together from one write
	property p_field_one_write;
		i_wr && sel_sync |=> {sync_q.v_force, sync_q.v_level, sync_q.h_force, sync_q.h_level}
			== $past(i_wdata[SYNC_FIELD_LSB +: SYNC_FIELD_W]);
	endproperty
	a_field_one_write: assert property (p_field_one_write) else $error("field not taken in one write");

	// keep-alive holds the syncs live while the dac is powered down
	property p_keep_alive;
		sync_q.keep_alive && !i_dac_enable && !sync_q.v_force |=> o_vsync == $past(i_vsync_normal);
	endproperty
	a_keep_alive: assert property (p_keep_alive) else $error("keep-alive did not hold vsync live");

	// video-out data input bit moves only with a write to its word
	property p_vid_capture;
		!vid_hit |=> $stable(pin_q[VIDEO_OUT_DATA_PIN].sampled_in);
	endproperty
	a_vid_capture: assert property (p_vid_capture) else $error("video-out input bit moved without write");

	// data pin level ignores a write without its mask
	property p_data_level_masked;
		mon_hit && !i_wdata[DATA_LANE_LSB + 2] |=> $stable(o_pin_out[MONITOR_CHANNEL_DATA_PIN]);
	endproperty
	a_data_level_masked: assert property (p_data_level_masked) else $error("data level moved without mask");

	// a masked level write reaches the pin in the next cycle
	property p_level_written;
		vid_hit && i_wdata[CLOCK_LANE_LSB + 2]
			|=> o_pin_out[VIDEO_OUT_CLOCK_PIN] == $past(i_wdata[CLOCK_LANE_LSB + 3]);
	endproperty
	a_level_written: assert property (p_level_written) else $error("level not taken with mask");

	// direction ignores a write without its mask
	property p_dir_masked;
		vid_hit && !i_wdata[DATA_LANE_LSB] |=> $stable(o_pin_oe[VIDEO_OUT_DATA_PIN]);
	endproperty
	a_dir_masked: assert property (p_dir_masked) else $error("direction changed without mask");

	// between pin writes nothing on the pin drive may move
	property p_pins_hold;
		!(i_wr && (sel_mon || sel_vid)) |=> $stable(o_pin_oe) && $stable(o_pin_out);
	endproperty
	a_pins_hold: assert property (p_pins_hold) else $error("pin drive moved without a write");

	// reset leaves every pin level low and both syncs quiet
	property p_reset_quiet;
		$rose(rst_n) |-> o_pin_out == '0 && !o_hsync && !o_vsync;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("pin or sync active after reset");

	// reserved bits around the two lanes read as zero
	property p_reserved_zero;
		i_rd && (sel_mon || sel_vid) |=> o_rdata[DATA_W-1:DATA_LANE_LSB+LANE_W] == '0
			&& o_rdata[DATA_LANE_LSB-1:CLOCK_LANE_LSB+LANE_W] == '0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved pin word bits not zero");

	// monitor channel clock lane reads back from the low lane
	property p_mon_readback;
		i_rd && sel_mon |=> o_rdata[CLOCK_LANE_LSB +: LANE_W] == $past(pin_q[MONITOR_CHANNEL_CLOCK_PIN]);
	endproperty
	a_mon_readback: assert property (p_mon_readback) else $error("monitor channel readback wrong");

	// idle cycles and unmapped reads show zero on the read port
	property p_read_idle;
		!i_rd || !(sel_sync || sel_mon || sel_vid) |=> o_rdata == READ_IDLE_VALUE;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read port not idle");

	// video-out data input also sits two flops behind its wire
	sequence s_vid_write_settled;
		vid_hit ##1 $past(rst_n, 3);
	endsequence

	property p_vid_sync_depth;
		s_vid_write_settled |-> pin_q[VIDEO_OUT_DATA_PIN].sampled_in == $past(i_pin_in[VIDEO_OUT_DATA_PIN], 3);
	endproperty
	a_vid_sync_depth: assert property (p_vid_sync_depth) else $error("video-out pin not two flops late");

endmodule : display_sync_gpio

`default_nettype wire

// *** verification/pin_partner.sv ***
// Purpose: far side of the four pins, monitor channel and video-out controller
// Assumes: open-drain lines with pull-ups on every pin
// Notes: any low wins, so a released line floats high
`timescale 1ns/1ps
`default_nettype none

module pin_partner
	import display_sync_gpio_pkg::*;
(
	input wire logic [PIN_COUNT-1:0] i_out, // block drive levels
	input wire logic [PIN_COUNT-1:0] i_oe, // block drive enables
	input wire logic [PIN_COUNT-1:0] i_pull_low, // far side holds line low
	output logic [PIN_COUNT-1:0] o_wire // resolved line levels
);
	// wired-and: never shows a stale level once the block lets go
	always_comb begin
		for (int k = 0; k < PIN_COUNT; k++) begin
			o_wire[k] = ~i_pull_low[k] & (i_oe[k] ? i_out[k] : 1'b1);
		end
	end
endmodule : pin_partner

`default_nettype wire

// *** verification/display_sync_gpio_tb.sv ***
// Purpose: random and corner checks of sync override and both pin pairs
// Assumes: seed 18, register port strobes driven right after rising edges
// Notes: expectations come from a small lane model kept in the bench
`timescale 1ns/1ps
`default_nettype none

module display_sync_gpio_tb;
	import display_sync_gpio_pkg::*;
	logic i_core_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0, o_rdata, rv, r, sd;
	logic i_hsync_normal = 0, i_vsync_normal = 0, i_dac_enable = 0;
	logic o_hsync, o_vsync, live;
	logic [PIN_COUNT-1:0] pin_wire, o_pin_out, o_pin_oe, pull_low = '0, eo, el;
	logic [3:0] lane_q [PIN_COUNT]; // expected level, level mask, direction, direction mask
	logic [PIN_COUNT-1:0] cap_q; // expected captured inputs
	int n_fail = 0, total_checks = 0, seed = 18, cyc = 0, p;

	display_sync_gpio display_sync_gpio_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_hsync_normal(i_hsync_normal), .i_vsync_normal(i_vsync_normal),
		.i_dac_enable(i_dac_enable), .o_hsync(o_hsync), .o_vsync(o_vsync),
		.i_pin_in(pin_wire), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
	pin_partner pin_partner_inst (.i_out(o_pin_out), .i_oe(o_pin_oe), .i_pull_low(pull_low),
		.o_wire(pin_wire));

	// free-running clock, 10 ns
	initial begin
		forever #5 i_core_clk = ~i_core_clk;
	end

	// hang guard, well above the expected run of some 1160 cycles
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic close_out;
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk

	task automatic chk_pins(input logic [PIN_COUNT-1:0] exp, input logic [PIN_COUNT-1:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t pins exp=%h got=%h", $time, exp, got);
		end
	endtask : chk_pins

	task automatic chk_sync(input logic [1:0] exp, input logic [1:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t syncs exp=%h got=%h", $time, exp, got);
		end
	endtask : chk_sync

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr

	// read data stand in the cycle after the strobe only
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd

	// masked update: level and direction move only with their mask
	function automatic logic [3:0] upd(input logic [3:0] o, input logic [4:0] w);
		return {w[2] ? w[3] : o[3], w[2], w[0] ? w[1] : o[1], w[0]};
	endfunction : upd

	// line level the rules predict, pull-up with wired-and
	function automatic logic wexp(input int k);
		return ~pull_low[k] & (lane_q[k][1] ? lane_q[k][3] : 1'b1);
	endfunction : wexp

	function automatic logic [31:0] rexp(input int q);
		return {19'h0, cap_q[2*q+1], lane_q[2*q+1], 3'h0, cap_q[2*q], lane_q[2*q]};
	endfunction : rexp

	function automatic logic [15:0] padr(input int q);
		return q ? VIDEO_OUT_PIN_CONTROL_OFFSET : MONITOR_CHANNEL_PIN_CONTROL_OFFSET;
	endfunction : padr

	initial begin
		for (int k = 0; k < PIN_COUNT; k++) lane_q[k] = 4'h0;
		cap_q = '0; // captured bits come out of reset low
		repeat (8) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		// reset values, sampled inputs excluded
		rd(SYNC_OVERRIDE_CONTROL_OFFSET, rv);
		chk(32'h0000_0000, rv);
		for (int q = 0; q < 2; q++) begin
			rd(padr(q), rv);
			chk(32'h0000_0000, rv & 32'hFFFF_EFEF);
		end
		chk_pins(4'h0, o_pin_oe);
		// random masked writes with the far side pulling lines meanwhile
		for (int i = 0; i < 60; i++) begin
			r = $random(seed);
			p = int'(r[8]);
			pull_low <= r[7:4];
			repeat (4) @(posedge i_core_clk);
			sd = $random(seed);
			cap_q[2*p] = wexp(2*p);
			cap_q[2*p+1] = wexp(2*p+1);
			lane_q[2*p] = upd(lane_q[2*p], sd[4:0]);
			lane_q[2*p+1] = upd(lane_q[2*p+1], sd[12:8]);
			wr(padr(p), sd);
			@(posedge i_core_clk);
			#1;
			for (int k = 0; k < PIN_COUNT; k++) begin
				eo[k] = lane_q[k][1];
				el[k] = lane_q[k][3] & lane_q[k][1];
			end
			chk_pins(eo, o_pin_oe);
			chk_pins(el, o_pin_out & o_pin_oe);
			// lines move, no write: captured bits must hold
			pull_low <= ~pull_low;
			repeat (4) @(posedge i_core_clk);
			rd(padr(p), rv);
			chk(rexp(p), rv);
			rd(padr(1 - p), rv);
			chk(rexp(1 - p), rv);
		end
		// unmapped place: ignored and reads zero
		wr(16'h5004, 32'hFFFF_FFFF);
		rd(16'h5004, rv);
		chk(32'h0000_0000, rv);
		rd(padr(0), rv);
		chk(rexp(0), rv);
		// every override code, with and without keep-alive
		for (int f = 0; f < 32; f++) begin
			r = $random(seed);
			i_hsync_normal <= r[0];
			i_vsync_normal <= r[1];
			i_dac_enable <= r[2];
			sd = {12'h0, f[3:0], 15'h0, f[4]};
			wr(SYNC_OVERRIDE_CONTROL_OFFSET, sd | ($random(seed) & 32'hFFF0_FFFE));
			repeat (3) @(posedge i_core_clk);
			#1 live = f[4] | r[2];
			chk_sync({live & (f[3] ? f[2] : r[1]), live & (f[1] ? f[0] : r[0])}, {o_vsync, o_hsync});
			rd(SYNC_OVERRIDE_CONTROL_OFFSET, rv);
			chk(sd, rv);
		end
		// second reset in mid-run, dac off so both syncs must fall quiet
		@(posedge i_core_clk);
		i_nrst <= 1'b0;
		i_dac_enable <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk_pins(4'h0, o_pin_oe);
		chk_pins(4'h0, o_pin_out);
		chk_sync(2'h0, {o_vsync, o_hsync});
		rd(SYNC_OVERRIDE_CONTROL_OFFSET, rv);
		chk(32'h0000_0000, rv);
		rd(padr(1), rv);
		chk(32'h0000_0000, rv);
		close_out();
	end
endmodule : display_sync_gpio_tb

`default_nettype wire
